//--- autoneg_np_map.vh
// Register offsets, field positions and reset values of the next-page bank
`ifndef AUTONEG_NP_MAP_VH
`define AUTONEG_NP_MAP_VH
`define REG_EXPANSION_STATUS     5'h06
`define REG_NEXT_PAGE_TRANSMIT   5'h07
`define REG_PARTNER_NEXT_PAGE    5'h08
`define EXP_PAR_DET_FAULT_BIT    4
`define EXP_PARTNER_NP_ABLE_BIT  3
`define EXP_LOCAL_NP_ABLE_BIT    2
`define EXP_PAGE_RECEIVED_BIT    1
`define EXP_PARTNER_AN_ABLE_BIT  0
`define NP_MORE_PAGES_BIT        15
`define NP_MESSAGE_PAGE_BIT      13
`define NP_ACK2_BIT              12
`define NP_TOGGLE_BIT            11
`define NP_CODE_MSB              10
`define NP_CODE_WIDTH            11
`define EXP_RESET_VALUE          16'h0004
`define NPTX_RESET_VALUE         16'h2001
`define NPRX_RESET_VALUE         16'h0000
`endif

//--- sticky_flag.v
// Latch-high status flag, cleared by a read, set wins over clear
`timescale 1ns/100ps
module sticky_flag (
    input  wire core_clk,
    input  wire rst_n,
    input  wire set_evt,
    input  wire clr_rd,
    output reg  flag_r
);
    always @(posedge core_clk) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (set_evt) begin
            flag_r <= 1'b1;
        end else if (clr_rd) begin
            flag_r <= 1'b0;
        end
    end
endmodule

//--- autoneg_next_page_regs.v
// Auto-negotiation expansion and next-page register bank
`timescale 1ns/100ps
`include "autoneg_np_map.vh"
module autoneg_next_page_regs #(
    parameter LOCAL_NP_ABLE = 1'b1
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [4:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    output reg         reg_rvalid,
    input  wire        par_det_fault_evt,
    input  wire        page_rx_evt,
    input  wire [15:0] page_rx_word,
    input  wire        partner_np_able,
    input  wire        partner_an_able,
    input  wire        tx_toggle,
    output wire [15:0] np_tx_word,
    output reg         np_tx_loaded
);
    localparam [15:0] NPTX_RST = `NPTX_RESET_VALUE;
    localparam [15:0] NPRX_RST = `NPRX_RESET_VALUE;

    // Transmit page fields, one register each
    reg                       more_pages_r;
    reg                       msg_page_r;
    reg                       ack2_r;
    reg  [`NP_CODE_WIDTH-1:0] code_r;

    // Received page and mirrored link status
    reg  [15:0]               nprx_r;
    reg                       partner_np_r;
    reg                       partner_an_r;
    reg                       toggle_r;

    // Next values of the bus side outputs and the engine load strobe
    reg                       loaded_nxt;
    reg                       rvalid_nxt;
    reg  [15:0]               rdata_nxt;

    wire                      fault_flag;
    wire                      page_flag;
    wire                      hit_exp;
    wire                      hit_nptx;
    wire                      hit_nprx;
    wire                      exp_rd;
    wire                      nptx_wr;
    wire [15:0]               exp_word;
    wire [15:0]               nprx_word;
    wire [15:0]               tx_mask;
    wire [15:0]               wdata_m;

    // Address compare
    function addr_hit;
        input [4:0] addr;
        input [4:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Writable bits of the transmit page
    function [15:0] tx_writable;
        input dummy;
        begin
            tx_writable = 16'h0000;
            tx_writable[`NP_MORE_PAGES_BIT] = 1'b1;
            tx_writable[`NP_MESSAGE_PAGE_BIT] = 1'b1;
            tx_writable[`NP_ACK2_BIT] = 1'b1;
            tx_writable[`NP_CODE_MSB:0] = {`NP_CODE_WIDTH{1'b1}};
        end
    endfunction

    // Page layout shared by both next-page registers; bit 14 always low
    function [15:0] pack_page;
        input                      more;
        input                      msg;
        input                      ack2;
        input                      tgl;
        input [`NP_CODE_WIDTH-1:0] code;
        begin
            pack_page = 16'h0000;
            pack_page[`NP_MORE_PAGES_BIT] = more;
            pack_page[`NP_MESSAGE_PAGE_BIT] = msg;
            pack_page[`NP_ACK2_BIT] = ack2;
            pack_page[`NP_TOGGLE_BIT] = tgl;
            pack_page[`NP_CODE_MSB:0] = code;
        end
    endfunction

    // Address decode
    assign hit_exp  = addr_hit(reg_addr, `REG_EXPANSION_STATUS);
    assign hit_nptx = addr_hit(reg_addr, `REG_NEXT_PAGE_TRANSMIT);
    assign hit_nprx = addr_hit(reg_addr, `REG_PARTNER_NEXT_PAGE);
    assign exp_rd   = reg_rd && hit_exp;
    assign nptx_wr  = reg_wr && hit_nptx;
    assign tx_mask  = tx_writable(1'b0);
    assign wdata_m  = reg_wdata & tx_mask;

    // Event flags, cleared by an expansion read
    sticky_flag u_fault (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_evt  (par_det_fault_evt),
        .clr_rd   (exp_rd),
        .flag_r   (fault_flag)
    );

    sticky_flag u_page (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_evt  (page_rx_evt),
        .clr_rd   (exp_rd),
        .flag_r   (page_flag)
    );

    // Expansion word
    assign exp_word[15:5] = 11'h000;
    assign exp_word[`EXP_PAR_DET_FAULT_BIT] = fault_flag;
    assign exp_word[`EXP_PARTNER_NP_ABLE_BIT] = partner_np_r;
    assign exp_word[`EXP_LOCAL_NP_ABLE_BIT] = LOCAL_NP_ABLE[0];
    assign exp_word[`EXP_PAGE_RECEIVED_BIT] = page_flag;
    assign exp_word[`EXP_PARTNER_AN_ABLE_BIT] = partner_an_r;

    // Transmit word with the registered engine toggle inserted
    assign np_tx_word = pack_page(more_pages_r, msg_page_r, ack2_r, toggle_r, code_r);

    // Partner word as received, reserved bit dropped
    assign nprx_word = pack_page(nprx_r[`NP_MORE_PAGES_BIT], nprx_r[`NP_MESSAGE_PAGE_BIT],
                                 nprx_r[`NP_ACK2_BIT], nprx_r[`NP_TOGGLE_BIT],
                                 nprx_r[`NP_CODE_MSB:0]);

    // Transmit page fields
    always @(posedge core_clk) begin
        if (!rst_n) begin
            more_pages_r <= NPTX_RST[`NP_MORE_PAGES_BIT];
            msg_page_r   <= NPTX_RST[`NP_MESSAGE_PAGE_BIT];
            ack2_r       <= NPTX_RST[`NP_ACK2_BIT];
            code_r       <= NPTX_RST[`NP_CODE_MSB:0];
        end else if (nptx_wr) begin
            more_pages_r <= wdata_m[`NP_MORE_PAGES_BIT];
            msg_page_r   <= wdata_m[`NP_MESSAGE_PAGE_BIT];
            ack2_r       <= wdata_m[`NP_ACK2_BIT];
            code_r       <= wdata_m[`NP_CODE_MSB:0];
        end
    end

    // Load strobe towards the negotiation engine
    always @* begin
        loaded_nxt = nptx_wr;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            np_tx_loaded <= 1'b0;
        end else begin
            np_tx_loaded <= loaded_nxt;
        end
    end

    // Toggle follows the engine, never the bus
    always @(posedge core_clk) begin
        if (!rst_n) begin
            toggle_r <= 1'b0;
        end else begin
            toggle_r <= tx_toggle;
        end
    end

    // Partner ability mirrors
    always @(posedge core_clk) begin
        if (!rst_n) begin
            partner_np_r <= 1'b0;
            partner_an_r <= 1'b0;
        end else begin
            partner_np_r <= partner_np_able;
            partner_an_r <= partner_an_able;
        end
    end

    // Received page, loaded only by the engine
    always @(posedge core_clk) begin
        if (!rst_n) begin
            nprx_r <= NPRX_RST;
        end else if (page_rx_evt) begin
            nprx_r <= page_rx_word;
        end
    end

    // Read select; data holds between reads
    always @* begin
        rvalid_nxt = reg_rd;
        rdata_nxt  = reg_rdata;
        if (reg_rd) begin
            if (hit_exp) begin
                rdata_nxt = exp_word;
            end else if (hit_nptx) begin
                rdata_nxt = np_tx_word;
            end else if (hit_nprx) begin
                rdata_nxt = nprx_word;
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    // Read data, registered
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= rdata_nxt;
            reg_rvalid <= rvalid_nxt;
        end
    end
endmodule

//--- np_sva.sv
// Checker for the next-page bank
`timescale 1ns/100ps
module np_sva (input wire core_clk, rst_n, reg_wr, reg_rd, page_rx_evt, par_det_fault_evt,
    partner_np_able, tx_toggle, input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata, reg_rdata, np_tx_word, page_rx_word);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire rd6 = reg_rd && reg_addr == 5'h06;
    wire rd8 = reg_rd && reg_addr == 5'h08;
    rsv_zero_a: assert property (rd6 |=> !reg_rdata[15:5]) else $error("rsv set");
    local_np_a: assert property (rd6 |=> reg_rdata[2]) else $error("np low");
    fault_set_a: assert property (par_det_fault_evt ##1 rd6 |=> reg_rdata[4])
        else $error("no fault");
    page_set_a: assert property (page_rx_evt ##1 rd6 |=> reg_rdata[1])
        else $error("no page");
    partner_np_a: assert property ($past(rst_n) && rd6 |=>
        reg_rdata[3] == $past(partner_np_able, 2)) else $error("np able");
    toggle_a: assert property ($past(rst_n) |-> np_tx_word[11] == $past(tx_toggle))
        else $error("toggle");
    tx_write_a: assert property (reg_wr && reg_addr == 5'h07 |=>
        (np_tx_word & 16'hF7FF) == ($past(reg_wdata) & 16'hB7FF)) else $error("tx word");
    rx_load_a: assert property (page_rx_evt ##1 rd8 |=>
        (reg_rdata & 16'hFFF0) == ($past(page_rx_word, 2) & 16'hBFF0)) else $error("rx page");
endmodule
bind autoneg_next_page_regs np_sva chk (.*);

//--- sta_model.sv
// Station manager model
`timescale 1ns/100ps
module sta_model (input wire core_clk, reg_rvalid, input wire [15:0] reg_rdata,
    output reg [4:0] reg_addr = 5'h00, output reg reg_wr = 1'b0, reg_rd = 1'b0,
    output reg [15:0] reg_wdata = 16'h0000);
    task wr(input [4:0] a, input [15:0] w); // One-cycle write strobe, data then inverted
        @(negedge core_clk) {reg_addr, reg_wr, reg_wdata} = {a, 1'b1, w};
        @(negedge core_clk) {reg_wr, reg_wdata} = {1'b0, ~w};
    endtask
    task rd(input [4:0] a, output [15:0] q);
        @(negedge core_clk) {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge core_clk) reg_rd = 1'b0;
        q = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask
endmodule

//--- tb_top.sv
// Next-page bank bench
`timescale 1ns/100ps
module tb_top;
    reg core_clk = 1'b0, rst_n = 1'b0, par_det_fault_evt = 1'b0, page_rx_evt = 1'b0;
    reg partner_np_able = 1'b0, partner_an_able = 1'b0, tx_toggle = 1'b0;
    reg [15:0] page_rx_word = 16'hFFFF, d;
    wire [15:0] reg_wdata, reg_rdata, np_tx_word;
    wire [4:0] reg_addr;
    wire reg_wr, reg_rd, reg_rvalid, np_tx_loaded;
    int error_cnt = 0, n_tests = 0;
    autoneg_next_page_regs dut (
        .core_clk          (core_clk),
        .rst_n             (rst_n),
        .reg_addr          (reg_addr),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .reg_rvalid        (reg_rvalid),
        .par_det_fault_evt (par_det_fault_evt),
        .page_rx_evt       (page_rx_evt),
        .page_rx_word      (page_rx_word),
        .partner_np_able   (partner_np_able),
        .partner_an_able   (partner_an_able),
        .tx_toggle         (tx_toggle),
        .np_tx_word        (np_tx_word),
        .np_tx_loaded      (np_tx_loaded)
    );
    sta_model sta (
        .core_clk   (core_clk),
        .reg_rvalid (reg_rvalid),
        .reg_rdata  (reg_rdata),
        .reg_addr   (reg_addr),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_wdata  (reg_wdata)
    );
    initial forever #5 core_clk = ~core_clk;
    task chk(input [15:0] g, e);
        n_tests++;
        error_cnt += (g !== e);
        if (g !== e) $display("unexpected %0t: %h not %h", $time, g, e);
    endtask
    task rdc(input [4:0] a, input [15:0] e);
        sta.rd(a, d);
        chk(d & (a == 5'h08 ? 16'hFFF0 : 16'hFFFF), e);
    endtask
    task print_verdict;
        $display("errors %0d of %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task t_write;
        chk(np_tx_word, 16'h2001);
        rdc(5'h08, 16'h0000);
        sta.wr(5'h07, 16'hFFFF);
        chk({15'h0000, np_tx_loaded}, 16'h0001);
        sta.wr(5'h06, 16'hFFFF);
        chk({15'h0000, np_tx_loaded}, 16'h0000);
        sta.wr(5'h08, 16'hFFFF);
        rdc(5'h07, 16'hB7FF);
        rdc(5'h06, 16'h0004);
        rdc(5'h08, 16'h0000);
    endtask
    task t_event;
        @(negedge core_clk) {par_det_fault_evt, page_rx_evt, partner_np_able} = 3'h7;
        {partner_an_able, tx_toggle} = 2'h3;
        @(negedge core_clk) {par_det_fault_evt, page_rx_evt} = 2'h0;
        rdc(5'h06, 16'h001F);
        rdc(5'h06, 16'h000D);
        rdc(5'h08, 16'hBFF0);
        chk(np_tx_word, 16'hBFFF);
        fork
            sta.rd(5'h06, d);
            begin
                @(negedge core_clk) page_rx_evt = 1'b1;
                @(negedge core_clk) page_rx_evt = 1'b0;
            end
        join
        chk(d, 16'h000D);
        rdc(5'h06, 16'h000F);
        rdc(5'h06, 16'h000D);
    endtask
    initial begin
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        t_write;
        t_event;
        print_verdict;
    end
    initial begin
        #2000;
        error_cnt++;
        print_verdict;
    end
endmodule
